/* File: diag_report_pkg.sv */
// constants, register map and record layout of the analog input diagnosis block
package diag_report_pkg;

  // ==========================================================================
  // clock and blink timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned FAST_HZ = 4;
  localparam int unsigned SLOW_HZ = 1;
  // a lamp is lit for half a period and dark for the other half
  localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned PRESC_W = 24;
  localparam logic [1:0] SLOW_DIV_LAST = 2'(FAST_HZ / SLOW_HZ - 1);

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CHAN_EN_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RECORD_OFS = 8'h10;
  localparam int unsigned RECORD_WORDS = 8;

  // control fields
  localparam int unsigned CTRL_CAPTURE_BIT = 0;
  localparam int unsigned CTRL_DIAG_EN_BIT = 1;
  localparam logic CTRL_DIAG_EN_RST = 1'b1;
  localparam logic [7:0] CHAN_EN_RST = 8'hFF;

  // status fields
  localparam int unsigned ST_RUN_BIT = 0;
  localparam int unsigned ST_ERR_BIT = 1;
  localparam int unsigned ST_SNAP_BIT = 2;
  localparam int unsigned ST_FAULT_BIT = 3;
  localparam int unsigned ST_LAMP_LSB = 8;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // diagnosis record
  localparam int unsigned RECORD_BYTES = 30;
  localparam int unsigned DEV_BYTES = 4;
  localparam int unsigned IDENT_BYTES = 2;
  localparam int unsigned CHAN_BYTES = 3;
  localparam int unsigned NUM_CHAN = 8;
  localparam logic [7:0] DEV_LEN_BYTE = 8'h04;
  localparam logic [7:0] IDENT_LEN_BYTE = 8'h42;
  localparam logic [7:0] IDENT_REPORT_BYTE = 8'h01;
  localparam logic [7:0] IDENT_IDLE_BYTE = 8'h00;
  localparam logic [7:0] CHAN_HEAD_BYTE = 8'h80;
  localparam logic [7:0] CHAN_INPUT_BASE = 8'h40;
  localparam logic [7:0] CODE_RECOVERY = 8'hA0;
  localparam logic [7:0] CODE_SHORT = 8'hA1;
  localparam logic [7:0] CODE_BREAK = 8'hA6;
  localparam logic [7:0] CODE_OVER_UPPER = 8'hA7;
  localparam logic [7:0] CODE_OVER_LOWER = 8'hA8;
  localparam logic [7:0] CODE_ACQUISITION = 8'hB2;
  // device byte field positions
  localparam int unsigned DEV2_MCU_BIT = 5;
  localparam int unsigned DEV3_NET_LSB = 6;
  localparam int unsigned DEV3_CHAN_BIT = 0;
  localparam int unsigned DEV4_PROG_BIT = 2;
  localparam int unsigned DEV4_ADC_BIT = 1;

endpackage

/* File: analog_input_diag_report.sv */
// status lamps and diagnosis record of the eight-channel current input module
`timescale 1ns/1ps
`default_nettype none

module analog_input_diag_report
  import diag_report_pkg::*;
#(
  parameter int unsigned FAST_HALF = FAST_HALF_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // per-channel sampling and field status
  input wire logic [7:0] main_sampler_bad,
  input wire logic [7:0] check_sampler_bad,
  input wire logic [7:0] short_circuit,
  input wire logic [7:0] wire_break,
  input wire logic [7:0] over_upper,
  input wire logic [7:0] over_lower,
  // module-level status
  input wire logic link_up,
  input wire logic link_error,
  input wire logic [1:0] net_fault,
  input wire logic mcu_fault,
  input wire logic program_fault,
  input wire logic adc_circuit_fault,
  // indicator lamps, high lights the lamp
  output logic run_lamp,
  output logic err_lamp,
  output logic [7:0] chan_lamp
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic diag_en;
    logic [7:0] chan_en;
    logic snap_valid;
    logic [DEV_BYTES-1:0][7:0] dev;
    logic [NUM_CHAN-1:0][7:0] code;
    logic [PRESC_W-1:0] presc;
    logic [1:0] slow_div;
    logic fast;
    logic slow;
    logic run;
    logic err;
    logic [7:0] lamp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ==========================================================================
  // helpers

  // fault code of one channel; acquisition trouble outranks wiring and range
  function automatic logic [7:0] chan_code(input logic acq, input logic sc, input logic br,
                                           input logic up, input logic lo, input logic en);
    logic [7:0] c;
    c = CODE_RECOVERY;
    if (acq) begin
      c = CODE_ACQUISITION;
    end else if (en && sc) begin
      c = CODE_SHORT;
    end else if (en && br) begin
      c = CODE_BREAK;
    end else if (en && up) begin
      c = CODE_OVER_UPPER;
    end else if (en && lo) begin
      c = CODE_OVER_LOWER;
    end
    return c;
  endfunction

  // one byte of the record, idx counts from zero
  function automatic logic [7:0] rec_byte(input logic [4:0] idx, input state_t s);
    logic [7:0] b;
    logic [4:0] rel;
    logic [2:0] ch;
    logic [1:0] pos;
    b = 8'h00;
    rel = 5'(idx - 5'(DEV_BYTES + IDENT_BYTES));
    ch = 3'(rel / 5'(CHAN_BYTES));
    pos = 2'(rel % 5'(CHAN_BYTES));
    if (idx < 5'(DEV_BYTES)) begin
      b = s.dev[idx[1:0]];
    end else if (idx == 5'(DEV_BYTES)) begin
      b = IDENT_LEN_BYTE;
    end else if (idx == 5'(DEV_BYTES + 1)) begin
      b = s.snap_valid ? IDENT_REPORT_BYTE : IDENT_IDLE_BYTE;
    end else if (idx < 5'(RECORD_BYTES)) begin
      // channel groups follow in channel order
      case (pos)
        2'd0: b = CHAN_HEAD_BYTE;
        2'd1: b = CHAN_INPUT_BASE | {5'h00, ch};
        default: b = s.code[ch];
      endcase
    end
    return b;
  endfunction

  // register read decode; the upper bit of the result flags a mapped address
  function automatic logic [32:0] reg_read(input logic [7:0] a, input state_t s,
                                           input logic fault);
    logic [32:0] r;
    logic [2:0] w;
    logic [4:0] base;
    r = {1'b0, 32'h0000_0000};
    w = 3'(a[7:2] - RECORD_OFS[7:2]);
    base = {w, 2'b00};
    if (a[7:2] == CTRL_OFS[7:2]) begin
      r = 33'h1_0000_0000;
      r[CTRL_DIAG_EN_BIT] = s.diag_en;
    end else if (a[7:2] == CHAN_EN_OFS[7:2]) begin
      r = {1'b1, 24'h00_0000, s.chan_en};
    end else if (a[7:2] == STATUS_OFS[7:2]) begin
      r = 33'h1_0000_0000;
      r[ST_RUN_BIT] = s.run;
      r[ST_ERR_BIT] = s.err;
      r[ST_SNAP_BIT] = s.snap_valid;
      r[ST_FAULT_BIT] = fault;
      r[ST_LAMP_LSB +: 8] = s.lamp;
    end else if (a[7:2] >= RECORD_OFS[7:2] &&
                 a[7:2] < 6'(RECORD_OFS[7:2] + 6'(RECORD_WORDS))) begin
      // four record bytes per word, lowest byte first; bytes past 30 read zero
      r = {1'b1, rec_byte(5'(base + 5'd3), s), rec_byte(5'(base + 5'd2), s),
           rec_byte(5'(base + 5'd1), s), rec_byte(base, s)};
    end
    return r;
  endfunction

  // ==========================================================================
  // live fault conditions

  logic [7:0] acq_bad;
  logic [7:0] wiring_bad;
  logic [7:0] range_bad;
  logic module_fault;

  // either sampling path out of order taints the channel value
  assign acq_bad = main_sampler_bad | check_sampler_bad;
  assign wiring_bad = short_circuit | wire_break;
  assign range_bad = over_upper | over_lower;
  // only enabled channels can fault the module
  assign module_fault = mcu_fault | program_fault | adc_circuit_fault |
                        (|(acq_bad & s_q.chan_en));

  // ==========================================================================
  // next state
  always_comb begin
    logic [32:0] rd;
    logic wr_now;
    logic [7:0] cc;
    rd = 33'h0_0000_0000;
    wr_now = 1'b0;
    cc = 8'h00;
    s_d = s_q;

    // write address and data are taken in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.waddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // both halves in hand and no response pending: perform the write
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      wr_now = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_SLVERR;
      if (s_q.waddr[7:2] == CTRL_OFS[7:2]) begin
        s_d.bresp = RESP_OKAY;
        if (s_q.wstrb[0]) begin
          s_d.diag_en = s_q.wdata[CTRL_DIAG_EN_BIT];
        end
      end else if (s_q.waddr[7:2] == CHAN_EN_OFS[7:2]) begin
        s_d.bresp = RESP_OKAY;
        if (s_q.wstrb[0]) begin
          s_d.chan_en = s_q.wdata[7:0];
        end
      end else if (s_q.waddr[7:2] == STATUS_OFS[7:2] ||
                   (s_q.waddr[7:2] >= RECORD_OFS[7:2] &&
                    s_q.waddr[7:2] < 6'(RECORD_OFS[7:2] + 6'(RECORD_WORDS)))) begin
        s_d.bresp = RESP_OKAY; // read-only words ignore the data
      end
    end
    // ready only while idle, so a new pair never overruns a pending response
    s_d.awready = !s_d.aw_got && !s_d.bvalid && !wr_now;
    s_d.wready = !s_d.w_got && !s_d.bvalid && !wr_now;

    // read channel: one read in flight, data held until taken
    if (rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      rd = reg_read(araddr, s_q, module_fault);
      s_d.rvalid = 1'b1;
      s_d.rdata = rd[31:0];
      s_d.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;

    // capture freezes the record so a slow fetch sees one consistent picture
    if (wr_now && s_q.waddr[7:2] == CTRL_OFS[7:2] && s_q.wstrb[0] &&
        s_q.wdata[CTRL_CAPTURE_BIT]) begin
      s_d.snap_valid = 1'b1;
      s_d.dev[0] = DEV_LEN_BYTE;
      s_d.dev[1] = 8'h00;
      s_d.dev[1][DEV2_MCU_BIT] = mcu_fault;
      s_d.dev[2] = 8'h00;
      s_d.dev[2][DEV3_NET_LSB +: 2] = net_fault;
      s_d.dev[2][DEV3_CHAN_BIT] = |(acq_bad & s_q.chan_en);
      s_d.dev[3] = 8'h00;
      s_d.dev[3][DEV4_PROG_BIT] = program_fault;
      s_d.dev[3][DEV4_ADC_BIT] = adc_circuit_fault;
      for (int i = 0; i < NUM_CHAN; i++) begin
        cc = chan_code(acq_bad[i], short_circuit[i], wire_break[i], over_upper[i],
                       over_lower[i], s_q.diag_en);
        s_d.code[i] = cc;
      end
    end

    // one prescaler feeds both rates, so all lamps of a rate stay in phase
    if (s_q.presc == PRESC_W'(FAST_HALF - 1)) begin
      s_d.presc = '0;
      s_d.fast = !s_q.fast;
      s_d.slow_div = 2'(s_q.slow_div + 2'd1);
      if (s_q.slow_div == SLOW_DIV_LAST) begin
        s_d.slow = !s_q.slow;
      end
    end else begin
      s_d.presc = PRESC_W'(s_q.presc + 1'b1);
    end

    // run lamp: fault blacks it out before the link state is looked at
    if (module_fault) begin
      s_d.run = 1'b0;
    end else if (link_up && !link_error) begin
      s_d.run = 1'b1;
    end else begin
      s_d.run = s_q.fast;
    end
    s_d.err = module_fault;

    // channel lamps: disabled, wiring or sampling fault, range, normal
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (!s_q.chan_en[i]) begin
        s_d.lamp[i] = 1'b0;
      end else if (wiring_bad[i] || acq_bad[i]) begin
        s_d.lamp[i] = s_q.fast;
      end else if (range_bad[i]) begin
        s_d.lamp[i] = s_q.slow;
      end else begin
        s_d.lamp[i] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.diag_en <= CTRL_DIAG_EN_RST;
      s_q.chan_en <= CHAN_EN_RST;
      s_q.dev[0] <= DEV_LEN_BYTE;
      for (int i = 0; i < NUM_CHAN; i++) begin
        s_q.code[i] <= CODE_RECOVERY;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs straight from the state register
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign run_lamp = s_q.run;
  assign err_lamp = s_q.err;
  assign chan_lamp = s_q.lamp;

  // protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot};

endmodule
`default_nettype wire

/* File: analog_input_diag_report_sva.sv */
// checker for lamp timing and record words
`timescale 1ns/1ps
`default_nettype none
// ====
// lamp and record checker
module analog_input_diag_report_sva #(
  parameter int unsigned FAST_HALF = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read channel
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  // status inputs
  input wire logic [7:0] main_sampler_bad,
  input wire logic [7:0] check_sampler_bad,
  input wire logic link_up,
  input wire logic link_error,
  input wire logic mcu_fault,
  input wire logic program_fault,
  input wire logic adc_circuit_fault,
  // lamps
  input wire logic run_lamp,
  input wire logic err_lamp
);
  typedef struct packed {
    logic prev;
    logic [23:0] cnt;
  } mon_t;
  mon_t mon_q, mon_d;
  logic ok_c, blink_c, rd_c;
  // disabled channels count as faulty here, which only narrows the checks
  assign ok_c = !(mcu_fault | program_fault | adc_circuit_fault) &&
    (main_sampler_bad | check_sampler_bad) == 8'h00;
  assign blink_c = ok_c && !(link_up && !link_error);
  assign rd_c = arvalid && arready;
  // cycles the run lamp has held still while it should blink
  always_comb begin
    mon_d.prev = run_lamp;
    mon_d.cnt = (!blink_c || run_lamp != mon_q.prev) ? 24'h0 : mon_q.cnt + 24'h1;
  end
  // monitor register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_q <= '0;
    end else begin
      mon_q <= mon_d;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_run_dark; mcu_fault || program_fault |=> !run_lamp; endproperty
  a_run_dark: assert property (p_run_dark) else $error("run lamp lit in fault");
  property p_err_on; adc_circuit_fault |=> err_lamp; endproperty
  a_err_on: assert property (p_err_on) else $error("fault lamp dark in fault");
  property p_err_off; ok_c |=> !err_lamp; endproperty
  a_err_off: assert property (p_err_off) else $error("fault lamp lit when clean");
  property p_run_on; ok_c && link_up && !link_error |=> run_lamp; endproperty
  a_run_on: assert property (p_run_on) else $error("run lamp not steady");
  property p_fast_span; mon_q.cnt <= 24'(FAST_HALF + 1); endproperty
  a_fast_span: assert property (p_fast_span) else $error("run lamp stuck");
  property p_ident; rd_c && araddr == 8'h14 |=> rvalid && rdata[31:16] == 16'h4080 &&
    rdata[7:0] == 8'h42; endproperty
  a_ident: assert property (p_ident) else $error("ident word wrong");
  property p_dev_len; rd_c && araddr == 8'h10 |=> rdata[7:0] == 8'h04; endproperty
  a_dev_len: assert property (p_dev_len) else $error("device length wrong");
  property p_tail; rd_c && araddr == 8'h2C |=> rdata[31:16] == 16'h0000 &&
    rdata[7:0] == 8'h47; endproperty
  a_tail: assert property (p_tail) else $error("record tail wrong");
endmodule
bind analog_input_diag_report analog_input_diag_report_sva #(.FAST_HALF(FAST_HALF)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready), .araddr(araddr),
  .rvalid(rvalid), .rdata(rdata), .main_sampler_bad(main_sampler_bad),
  .check_sampler_bad(check_sampler_bad), .link_up(link_up), .link_error(link_error),
  .mcu_fault(mcu_fault), .program_fault(program_fault),
  .adc_circuit_fault(adc_circuit_fault), .run_lamp(run_lamp), .err_lamp(err_lamp));
`default_nettype wire

/* File: diag_fetch_master.sv */
// bus master model of the controller fetching the record
`timescale 1ns/1ps
`default_nettype none
// ====
// controller model
module diag_fetch_master (
  // clock
  input wire logic aclk,
  // write channels
  output logic awvalid,
  output logic [7:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic bready,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  // read channels
  output logic arvalid,
  output logic [7:0] araddr,
  output logic [2:0] arprot,
  output logic rready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // idle bus; only lane 0 matters, so all strobes stay on
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, awprot, arprot} = '0;
    wstrb = 4'hF;
  end
  // one write; each half is held until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
    // one idle edge, so a following call never reassigns bready in the same step
    @(posedge aclk);
  endtask
  // one read; data taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    // one idle edge, so a following call never reassigns rready in the same step
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* File: analog_input_diag_report_test.sv */
// bench comparing lamps and record words with a reference model
`timescale 1ns/1ps
`default_nettype none
// ====
// testbench top
module analog_input_diag_report_test
  import diag_report_pkg::*;
;
  localparam int FH = 4;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, lnk, lerr, mcu, prg, adc, run_lamp, err_lamp;
  logic [7:0] awaddr, araddr, mbad, cbad, shrt, brk, upr, lwr, chan_lamp;
  logic [31:0] wdata, rdata;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, net;
  int fails, samples_checked, en, de, seed;
  int rec[32];
  // clock, 40 ns period
  always #20 aclk = ~aclk;
  analog_input_diag_report #(.FAST_HALF(FH)) u_analog_input_diag_report (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .main_sampler_bad(mbad), .check_sampler_bad(cbad), .short_circuit(shrt),
    .wire_break(brk), .over_upper(upr), .over_lower(lwr), .link_up(lnk), .link_error(lerr),
    .net_fault(net), .mcu_fault(mcu), .program_fault(prg), .adc_circuit_fault(adc),
    .run_lamp(run_lamp), .err_lamp(err_lamp), .chan_lamp(chan_lamp));
  diag_fetch_master u_master (
    .aclk(aclk), .awvalid(awvalid), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
    .wdata(wdata), .wstrb(wstrb), .bready(bready), .awready(awready), .wready(wready),
    .bvalid(bvalid), .bresp(bresp), .arvalid(arvalid), .araddr(araddr), .arprot(arprot),
    .rready(rready), .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp));
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // sparse random mask: each bit set with chance 2 to the minus k
  function automatic logic [7:0] rnd(int k);
    logic [7:0] v;
    v = 8'hFF;
    repeat (k) v &= 8'($urandom);
    return v;
  endfunction
  function automatic int code(int c);
    if (mbad[c] | cbad[c]) return CODE_ACQUISITION;
    if (de && shrt[c]) return CODE_SHORT;
    if (de && brk[c]) return CODE_BREAK;
    if (de && upr[c]) return CODE_OVER_UPPER;
    if (de && lwr[c]) return CODE_OVER_LOWER;
    return CODE_RECOVERY;
  endfunction
  // read all eight record words, channel summary bit included
  task automatic check_record();
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
    for (int w = 0; w < 8; w++) begin
      u_master.rd(RECORD_OFS + 8'(4 * w), d, r);
      e = {8'(rec[4*w+3]), 8'(rec[4*w+2]), 8'(rec[4*w+1]), 8'(rec[4*w])};
      check(d, e);
    end
  endtask
  // count lamp changes over 64 cycles: steady lamps give their level, blinking ones a rate
  task automatic check_lamps();
    logic [9:0] prv, cur, fst;
    logic [31:0] g, e, d;
    logic [1:0] r;
    int n[10];
    int f, m;
    repeat (6) @(posedge aclk);
    fst = {chan_lamp, err_lamp, run_lamp};
    prv = fst;
    n = '{default: 0};
    repeat (64) begin
      @(posedge aclk);
      cur = {chan_lamp, err_lamp, run_lamp};
      for (int i = 0; i < 10; i++) n[i] += int'(cur[i] !== prv[i]);
      prv = cur;
    end
    f = mcu | prg | adc | (((mbad | cbad) & 8'(en)) != 8'h00);
    for (int i = 0; i < 10; i++) begin
      if (i == 0) m = f ? 0 : (lnk && !lerr) ? 1 : 2;
      else if (i == 1) m = f;
      else if (!en[i-2]) m = 0;
      else if (mbad[i-2] | cbad[i-2] | shrt[i-2] | brk[i-2]) m = 2;
      else if (upr[i-2] | lwr[i-2]) m = 3;
      else m = 1;
      // four-state result, so an unknown lamp cannot pass as dark
      g = n[i] == 0 ? 32'(fst[i]) : 32'(2 * n[i]);
      e = m < 2 ? 32'(m) : m == 2 ? 32'(128 / FH) : 32'(32 / FH);
      check(g, e);
    end
    // status word: live fault, snapshot flag and fault lamp are all steady here
    u_master.rd(STATUS_OFS, d, r);
    check(32'(d[3:1]), 32'({f != 0, rec[5] != 0, f != 0}));
  endtask
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    aclk = 1'b0;
    aresetn = 1'b0;
    {mbad, cbad, shrt, brk, upr, lwr, lnk, lerr, mcu, prg, adc, net} = '0;
    fails = 0;
    samples_checked = 0;
    en = 255;
    de = 1;
    seed = $urandom(70773);
    rec = '{default: 0};
    rec[0] = DEV_LEN_BYTE;
    rec[4] = IDENT_LEN_BYTE;
    for (int c = 0; c < 8; c++) begin
      rec[6 + 3 * c] = CHAN_HEAD_BYTE;
      rec[7 + 3 * c] = CHAN_INPUT_BASE + c;
      rec[8 + 3 * c] = CODE_RECOVERY;
    end
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    u_master.rd(CTRL_OFS, d, r);
    check(d, 32'h0000_0002);
    u_master.rd(CHAN_EN_OFS, d, r);
    check(d, 32'(CHAN_EN_RST));
    u_master.rd(8'h40, d, r);
    check({d[29:0], r}, {30'h0, RESP_SLVERR});
    u_master.wr(8'h40, 32'hFFFF_FFFF, r);
    check(32'(r), 32'(RESP_SLVERR));
    check_record();
    repeat (16) begin
      mbad <= rnd(5);
      cbad <= rnd(5);
      shrt <= rnd(4);
      brk <= rnd(4);
      upr <= rnd(3);
      lwr <= rnd(3);
      lnk <= ($urandom % 3) != 0;
      lerr <= ($urandom % 4) == 0;
      mcu <= ($urandom % 6) == 0;
      prg <= ($urandom % 6) == 0;
      adc <= ($urandom % 6) == 0;
      net <= 2'($urandom % 3);
      en = $urandom & 255;
      u_master.wr(CHAN_EN_OFS, 32'(en), r);
      check_lamps();
      check_record();
      en = 255;
      de = $urandom & 1;
      u_master.wr(CHAN_EN_OFS, 32'(en), r);
      // capture grades codes with the enable already in force, so set it first
      u_master.wr(CTRL_OFS, 32'(2 * de), r);
      u_master.wr(CTRL_OFS, 32'(1 + 2 * de), r);
      check(32'(r), 32'(RESP_OKAY));
      rec[1] = int'(mcu) << DEV2_MCU_BIT;
      rec[2] = (int'(net) << DEV3_NET_LSB) | (int'((mbad | cbad) != 8'h00) << DEV3_CHAN_BIT);
      rec[3] = (int'(prg) << DEV4_PROG_BIT) | (int'(adc) << DEV4_ADC_BIT);
      rec[5] = IDENT_REPORT_BYTE;
      for (int c = 0; c < 8; c++) rec[8 + 3 * c] = code(c);
      check_record();
    end
    end_of_test();
  end
  // watchdog: the run needs about 2200 cycles, so 20000 means a hang
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
